// ===== psar_pkg.sv
`default_nettype none
package psar_pkg;
   // ----------------------------------------
   // register indexes
   // ----------------------------------------
   localparam logic [4:0] IDX_STATUS   = 5'h01;
   localparam logic [4:0] IDX_ID_HIGH  = 5'h02;
   localparam logic [4:0] IDX_ID_LOW   = 5'h03;
   localparam logic [4:0] IDX_ADVERT   = 5'h04;
   localparam logic [4:0] IDX_PARTNER  = 5'h05;

   // ----------------------------------------
   // status field positions
   // ----------------------------------------
   localparam int ST_JABBER   = 1;
   localparam int ST_LINK     = 2;
   localparam int ST_RFAULT   = 4;
   localparam int ST_AN_DONE  = 5;
   localparam logic [15:0] ST_FIXED = 16'h7809;

   // ----------------------------------------
   // advertisement layout
   // ----------------------------------------
   localparam logic [15:0] ADV_WR_MASK   = 16'h3DFF;
   localparam logic [15:0] ADV_RESET     = 16'h0081;
   localparam logic [15:0] ADV_STRAP_MSK = 16'h0160;
   localparam logic [15:0] LP_KEEP_MASK  = 16'h2FE0;
   localparam logic [4:0]  SELECTOR_8023 = 5'b0_0001;

   // ----------------------------------------
   // identity words (arbitrary values)
   // ----------------------------------------
   localparam logic [15:0] OUI_MID_BITS = 16'h1234;
   localparam logic [5:0]  OUI_LOW_BITS = 6'h15;
   localparam logic [5:0]  MODEL_NUM    = 6'h0A;
   localparam logic [3:0]  REVISION_NUM = 4'h1;

   typedef struct packed {
      logic        req;
      logic        write;
      logic [4:0]  index;
      logic [15:0] wdata;
   } psar_req_t;

   typedef struct packed {
      logic        done;
      logic [15:0] rdata;
   } psar_rsp_t;

   typedef struct packed {
      logic        an_done;
      logic        rfault;
      logic        link_up;
      logic        jabber;
      logic [15:0] partner_word;
   } psar_ev_t;
endpackage : psar_pkg
`default_nettype wire

// ===== psar_latch.sv
`timescale 1ns/1ns
`default_nettype none
module psar_latch
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic cond,
   input  wire logic read_ack,
   output var  logic flag
);
   typedef struct packed {
      logic held;
   } psar_latch_st_t;

   psar_latch_st_t st_reg;
   psar_latch_st_t st_next;

   // ----------------------------------------
   // latching-high: set wins over the clear on read
   // ----------------------------------------
   always_comb
   begin
      st_next = st_reg;
      if (read_ack)
         st_next.held = 1'b0;
      if (cond)
         st_next.held = 1'b1;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign flag = st_reg.held | cond;

   a_latch_hold : assert property (@(posedge clk_sys) disable iff (rst)
      (cond && !read_ack) |=> flag) else $error("latched flag dropped");
endmodule : psar_latch
`default_nettype wire

// ===== psar_regs.sv
`timescale 1ns/1ns
`default_nettype none
module psar_regs
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              speed_strap,
   input  wire psar_pkg::psar_req_t mgmt_req,
   input  wire psar_pkg::psar_ev_t  phy_ev,
   output var  psar_pkg::psar_rsp_t mgmt_rsp
);
   typedef struct packed {
      logic                strap_done;
      logic                link_low;
      logic [15:0]         advert;
      logic [15:0]         partner;
      psar_pkg::psar_rsp_t rsp;
   } psar_st_t;

   psar_st_t st_reg;
   psar_st_t st_next;

   logic rfault_flag;
   logic jabber_flag;
   logic status_read;
   logic [15:0] status_word;
   logic [15:0] read_word;

   assign status_read = mgmt_req.req && !mgmt_req.write && (mgmt_req.index == psar_pkg::IDX_STATUS);

   // ----------------------------------------
   // latching-high status sources
   // ----------------------------------------
   // remote fault latch
   psar_latch u_rfault
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .cond     (phy_ev.rfault),
      .read_ack (status_read),
      .flag     (rfault_flag)
   );

   psar_latch u_jabber
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .cond     (phy_ev.jabber),
      .read_ack (status_read),
      .flag     (jabber_flag)
   );

   // ----------------------------------------
   // status word assembly
   // ----------------------------------------
   always_comb
   begin
      status_word = psar_pkg::ST_FIXED;
      status_word[psar_pkg::ST_AN_DONE] = phy_ev.an_done;
      status_word[psar_pkg::ST_RFAULT]  = rfault_flag;
      status_word[psar_pkg::ST_LINK]    = phy_ev.link_up && !st_reg.link_low;
      status_word[psar_pkg::ST_JABBER]  = jabber_flag;
   end

   // ----------------------------------------
   // index decode
   // ----------------------------------------
   // indexed access
   always_comb
   begin
      case (mgmt_req.index)
         psar_pkg::IDX_STATUS:  read_word = status_word;
         psar_pkg::IDX_ID_HIGH: read_word = psar_pkg::OUI_MID_BITS;
         psar_pkg::IDX_ID_LOW:  read_word = {psar_pkg::OUI_LOW_BITS, psar_pkg::MODEL_NUM, psar_pkg::REVISION_NUM};
         psar_pkg::IDX_ADVERT:  read_word = st_reg.advert;
         psar_pkg::IDX_PARTNER: read_word = st_reg.partner;
         default:               read_word = 16'h0000;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.rsp.done = 1'b0;
      if (!st_reg.strap_done)
      begin
         st_next.strap_done = 1'b1;
         st_next.advert = speed_strap ? (st_reg.advert | psar_pkg::ADV_STRAP_MSK)
                                      : (st_reg.advert & ~psar_pkg::ADV_STRAP_MSK);
      end
      // link loss held until status read
      if (status_read)
         st_next.link_low = 1'b0;
      if (!phy_ev.link_up)
         st_next.link_low = 1'b1;
      st_next.partner = (phy_ev.partner_word & psar_pkg::LP_KEEP_MASK) | {11'h000, psar_pkg::SELECTOR_8023};
      if (mgmt_req.req)
      begin
         st_next.rsp.done = 1'b1;
         st_next.rsp.rdata = read_word;
         if (mgmt_req.write && mgmt_req.index == psar_pkg::IDX_ADVERT)
            st_next.advert = mgmt_req.wdata & psar_pkg::ADV_WR_MASK;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.link_low <= 1'b1;
         st_reg.advert <= psar_pkg::ADV_RESET;
         st_reg.partner <= {11'h000, psar_pkg::SELECTOR_8023};
      end
      else
         st_reg <= st_next;
   end

   assign mgmt_rsp = st_reg.rsp;

   a_adv_fixed : assert property (@(posedge clk_sys) disable iff (rst)
      st_reg.advert[15:14] == 2'b00 && !st_reg.advert[9]) else $error("advert fixed bits set");
   a_partner_fixed : assert property (@(posedge clk_sys) disable iff (rst)
      st_reg.partner[15:14] == 2'b00 && st_reg.partner[4:0] == 5'b0_0001) else $error("partner fixed bits");
   a_status_read : assert property (@(posedge clk_sys) disable iff (rst)
      (mgmt_req.req && !mgmt_req.write && mgmt_req.index == psar_pkg::IDX_STATUS)
      |=> mgmt_rsp.done && mgmt_rsp.rdata[15:11] == 5'b0_1111 && mgmt_rsp.rdata[10:6] == 5'h00)
      else $error("status abilities wrong");
   a_link_latch : assert property (@(posedge clk_sys) disable iff (rst)
      !phy_ev.link_up ##1 (mgmt_req.req && !mgmt_req.write && mgmt_req.index == psar_pkg::IDX_STATUS)
      |=> !mgmt_rsp.rdata[2]) else $error("link loss not held");
   a_adv_write : assert property (@(posedge clk_sys) disable iff (rst)
      (mgmt_req.req && mgmt_req.write && mgmt_req.index == psar_pkg::IDX_ADVERT && st_reg.strap_done)
      |=> st_reg.advert == ($past(mgmt_req.wdata) & 16'h3DFF)) else $error("advert write lost");
   a_id_read : assert property (@(posedge clk_sys) disable iff (rst)
      (mgmt_req.req && !mgmt_req.write && mgmt_req.index == psar_pkg::IDX_ID_HIGH)
      |=> mgmt_rsp.rdata == psar_pkg::OUI_MID_BITS) else $error("identifier wrong");
   a_an_done : assert property (@(posedge clk_sys) disable iff (rst)
      (status_read && !phy_ev.an_done) |=> !mgmt_rsp.rdata[5]) else $error("an done early");
   a_strap_load : assert property (@(posedge clk_sys) disable iff (rst)
      (!st_reg.strap_done && speed_strap) |=> st_reg.advert[8]) else $error("strap not loaded");

   // ----------------------------------------
   // access sequences
   // ----------------------------------------
   sequence s_status_rd;
      mgmt_req.req && !mgmt_req.write && (mgmt_req.index == psar_pkg::IDX_STATUS);
   endsequence : s_status_rd

   sequence s_unmapped_rd;
      mgmt_req.req && !mgmt_req.write &&
      (mgmt_req.index == 5'h00 || mgmt_req.index > psar_pkg::IDX_PARTNER);
   endsequence : s_unmapped_rd

   sequence s_id_low_rd;
      mgmt_req.req && !mgmt_req.write && (mgmt_req.index == psar_pkg::IDX_ID_LOW);
   endsequence : s_id_low_rd

   sequence s_advert_rd;
      mgmt_req.req && !mgmt_req.write && (mgmt_req.index == psar_pkg::IDX_ADVERT);
   endsequence : s_advert_rd

   sequence s_partner_rd;
      mgmt_req.req && !mgmt_req.write && (mgmt_req.index == psar_pkg::IDX_PARTNER);
   endsequence : s_partner_rd

   // condition seen without a read, then a status read
   sequence s_rf_then_read;
      (phy_ev.rfault && !status_read) ##1 status_read;
   endsequence : s_rf_then_read

   sequence s_jb_then_read;
      (phy_ev.jabber && !status_read) ##1 status_read;
   endsequence : s_jb_then_read

   // two quiet status reads with a quiet cycle between
   sequence s_quiet_read_pair;
      (status_read && !phy_ev.rfault && !phy_ev.jabber)
      ##1 (!phy_ev.rfault && !phy_ev.jabber)
      ##1 (status_read && !phy_ev.rfault && !phy_ev.jabber);
   endsequence : s_quiet_read_pair

   // ----------------------------------------
   // response handshake checks
   // ----------------------------------------
   // one answer per request
   a_rsp_pulse : assert property (@(posedge clk_sys) disable iff (rst)
      mgmt_req.req |=> mgmt_rsp.done) else $error("request not answered");

   a_no_spurious : assert property (@(posedge clk_sys) disable iff (rst)
      !mgmt_req.req |=> !mgmt_rsp.done) else $error("answer without request");

   a_unmapped_zero : assert property (@(posedge clk_sys) disable iff (rst)
      s_unmapped_rd |=> mgmt_rsp.rdata == 16'h0000) else $error("unmapped index not zero");

   // ----------------------------------------
   // fixed word checks
   // ----------------------------------------
   // identifier low fields
   a_id_low_read : assert property (@(posedge clk_sys) disable iff (rst)
      s_id_low_rd |=> mgmt_rsp.rdata == {psar_pkg::OUI_LOW_BITS, psar_pkg::MODEL_NUM, psar_pkg::REVISION_NUM})
      else $error("identifier low wrong");

   a_status_caps : assert property (@(posedge clk_sys) disable iff (rst)
      s_status_rd |=> mgmt_rsp.rdata[3] && mgmt_rsp.rdata[0]) else $error("capability bits clear");

   a_advert_read : assert property (@(posedge clk_sys) disable iff (rst)
      s_advert_rd |=> mgmt_rsp.rdata[15:14] == 2'b00 && !mgmt_rsp.rdata[9]) else $error("advert read fixed bits");

   a_partner_read : assert property (@(posedge clk_sys) disable iff (rst)
      s_partner_rd |=> mgmt_rsp.rdata[15:14] == 2'b00 && !mgmt_rsp.rdata[12] && mgmt_rsp.rdata[4:0] == 5'b0_0001)
      else $error("partner read fixed bits");

   // ----------------------------------------
   // live status bit checks
   // ----------------------------------------
   // completion shown
   a_an_done_set : assert property (@(posedge clk_sys) disable iff (rst)
      (status_read && phy_ev.an_done) |=> mgmt_rsp.rdata[5]) else $error("an done not shown");

   a_rfault_show : assert property (@(posedge clk_sys) disable iff (rst)
      (status_read && phy_ev.rfault) |=> mgmt_rsp.rdata[4]) else $error("remote fault not shown");

   a_jabber_show : assert property (@(posedge clk_sys) disable iff (rst)
      (status_read && phy_ev.jabber) |=> mgmt_rsp.rdata[1]) else $error("jabber not shown");

   a_link_down : assert property (@(posedge clk_sys) disable iff (rst)
      (status_read && !phy_ev.link_up) |=> !mgmt_rsp.rdata[2]) else $error("link down not shown");

   // ----------------------------------------
   // latch behaviour checks
   // ----------------------------------------
   // fault held until read
   a_rfault_held : assert property (@(posedge clk_sys) disable iff (rst)
      s_rf_then_read |=> mgmt_rsp.rdata[4]) else $error("remote fault not held");

   a_jabber_held : assert property (@(posedge clk_sys) disable iff (rst)
      s_jb_then_read |=> mgmt_rsp.rdata[1]) else $error("jabber not held");

   a_latch_clear : assert property (@(posedge clk_sys) disable iff (rst)
      s_quiet_read_pair |=> !mgmt_rsp.rdata[4] && !mgmt_rsp.rdata[1]) else $error("latch not cleared");

   // ----------------------------------------
   // advertisement checks
   // ----------------------------------------
   // strap low clears ability bits 8, 6 and 5, keeps bit 7
   a_strap_clear : assert property (@(posedge clk_sys) disable iff (rst)
      (!st_reg.strap_done && !speed_strap && !mgmt_req.req) |=> st_reg.advert[8:5] == 4'b0100)
      else $error("strap low not applied");

   a_strap_once : assert property (@(posedge clk_sys) disable iff (rst)
      st_reg.strap_done |=> st_reg.strap_done) else $error("strap reapplied");

   a_advert_hold : assert property (@(posedge clk_sys) disable iff (rst)
      (st_reg.strap_done && !(mgmt_req.req && mgmt_req.write && mgmt_req.index == psar_pkg::IDX_ADVERT))
      |=> $stable(st_reg.advert)) else $error("advert changed without write");

   // ----------------------------------------
   // partner word checks
   // ----------------------------------------
   // partner pause follows engine
   a_partner_pause : assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> st_reg.partner[11:10] == $past(phy_ev.partner_word[11:10])) else $error("partner pause wrong");

   a_partner_abil : assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> st_reg.partner[9:5] == $past(phy_ev.partner_word[9:5])
               && st_reg.partner[13] == $past(phy_ev.partner_word[13]))
      else $error("partner abilities wrong");
endmodule : psar_regs
`default_nettype wire

// ===== psar_mac_model.sv
`timescale 1ns/1ns
`default_nettype none
module psar_mac_model
(
   input  wire logic                clk_sys,
   input  wire psar_pkg::psar_rsp_t mgmt_rsp,
   output var  psar_pkg::psar_req_t mgmt_req
);
   initial mgmt_req = '0;

   task automatic access(input logic w, input logic [4:0] i, input logic [15:0] d,
                         output logic [15:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = '0;
      @(posedge clk_sys);
      mgmt_req <= '{1'b1, w, i, d};
      @(posedge clk_sys);
      // idle request lines show garbage, not the last value
      mgmt_req <= '{1'b0, ~w, ~i, ~d};
      for (n = 0; n < 2 && !ok; n++)
      begin
         #1;
         ok = (mgmt_rsp.done === 1'b1);
         q = mgmt_rsp.rdata;
         if (!ok)
            @(posedge clk_sys);
      end
   endtask : access
endmodule : psar_mac_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic                clk_sys;
   logic                rst;
   logic                speed_strap;
   psar_pkg::psar_ev_t  ev;
   psar_pkg::psar_req_t req;
   psar_pkg::psar_rsp_t rsp;
   int                  num_errors;
   int                  cmp_count;
   logic [15:0]         w;
   logic [15:0]         pw;

   psar_regs DUT (.clk_sys(clk_sys), .rst(rst), .speed_strap(speed_strap), .mgmt_req(req),
                  .phy_ev(ev), .mgmt_rsp(rsp));
   psar_mac_model mac (.clk_sys(clk_sys), .mgmt_rsp(rsp), .mgmt_req(req));

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [15:0] st(input logic an, input logic rf, input logic lk, input logic jb);
      return psar_pkg::ST_FIXED | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
   endfunction : st

   task automatic end_of_test();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   task automatic io(input logic wr, input logic [4:0] i, input logic [15:0] d, input logic [15:0] e);
      logic [15:0] q;
      logic        ok;
      mac.access(wr, i, d, q, ok);
      cmp_count++;
      if (ok !== 1'b1 || (!wr && q !== e))
      begin
         num_errors++;
         $display("[ERR] %0t idx %0d got %h exp %h done %b", $time, i, q, e, ok);
      end
      if (ok !== 1'b1)
         end_of_test();
   endtask : io

   initial
   begin
      void'($urandom(32'hd6ef_cdb6));
      num_errors = 0;
      cmp_count = 0;
      rst = 1'b1;
      ev = '0;
      speed_strap = $urandom;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      io(0, 5'h01, 16'h0000, st(0, 0, 0, 0));
      io(0, 5'h02, 16'h0000, psar_pkg::OUI_MID_BITS);
      io(0, 5'h03, 16'h0000, {psar_pkg::OUI_LOW_BITS, psar_pkg::MODEL_NUM, psar_pkg::REVISION_NUM});
      io(0, 5'h04, 16'h0000, speed_strap ? 16'h01E1 : 16'h0081);
      io(0, 5'h05, 16'h0000, 16'h0001);
      for (int k = 0; k < 12; k++)
      begin
         w = (k == 0) ? 16'hFFFF : 16'($urandom);
         w[11:10] = k[1:0];
         io(1, 5'h04, w, 16'h0000);
         io(0, 5'h04, 16'h0000, w & 16'h3DFF);
      end
      for (int j = 0; j < 8; j++)
         if (j != 4)
            io(1, j[4:0], 16'hFFFF, 16'h0000);
      io(0, 5'h03, 16'h0000, {psar_pkg::OUI_LOW_BITS, psar_pkg::MODEL_NUM, psar_pkg::REVISION_NUM});
      io(0, 5'h07, 16'h0000, 16'h0000);
      io(0, 5'h04, 16'h0000, w & 16'h3DFF);
      for (int k = 0; k < 6; k++)
      begin
         pw = (k == 0) ? 16'hFFFF : 16'($urandom);
         pw[11:10] = k[1:0];
         @(posedge clk_sys);
         ev.partner_word <= pw;
         io(0, 5'h05, 16'h0000, (pw & 16'h2FE0) | 16'h0001);
      end
      @(posedge clk_sys);
      ev.jabber <= 1'b1;
      ev.rfault <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ev.jabber <= 1'b0;
      ev.rfault <= 1'b0;
      repeat (2) @(posedge clk_sys);
      io(0, 5'h01, 16'h0000, st(0, 1, 0, 1));
      io(0, 5'h01, 16'h0000, st(0, 0, 0, 0));
      for (int r = 0; r < 2; r++)
      begin
         @(posedge clk_sys);
         ev.link_up <= 1'b0;
         @(posedge clk_sys);
         ev.link_up <= 1'b1;
         ev.an_done <= 1'b1;
         repeat (2) @(posedge clk_sys);
         io(0, 5'h01, 16'h0000, st(1, 0, 0, 0));
         io(0, 5'h01, 16'h0000, st(1, 0, 1, 0));
      end
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
